// [include/afe_params.svh]
// register offsets, reset values and widths of the analog front end control
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define AFE_OFF_PRIM_CFG   8'h00
`define AFE_OFF_AUX_CFG    8'h04
`define AFE_OFF_CUR_CFG    8'h08
`define AFE_OFF_STATUS     8'h0c
`define AFE_OFF_PRIM_RES   8'h10
`define AFE_OFF_AUX_RES    8'h14

// ****************************************************************
// reset values and widths
// ****************************************************************
`define AFE_PRIM_CFG_RST   6'h00
`define AFE_AUX_CFG_RST    3'h0
`define AFE_CUR_CFG_RST    5'h00
`define AFE_PRIM_RES_W     24
`define AFE_AUX_RES_W      16
`define AFE_RESP_OKAY      2'h0
`define AFE_RESP_SLVERR    2'h2

`endif

// [include/afe_pkg.sv]
// types shared by the analog front end control files
package afe_pkg;

    typedef enum logic [1:0] {
        PRIM_CH_1_2,
        PRIM_CH_3_4,
        PRIM_CH_3_2,
        PRIM_CH_2_2
    } afe_prim_chan_type;

    typedef enum logic [1:0] {
        AUX_PIN_3,
        AUX_PIN_4,
        AUX_PIN_5,
        AUX_TEMP
    } afe_aux_chan_type;

    typedef enum logic [1:0] {
        SETTLE_WAIT0,
        SETTLE_WAIT1,
        SETTLE_DONE
    } afe_settle_state_type;

    // primary_converter_control layout
    typedef struct packed {
        afe_prim_chan_type chan;
        logic              unipolar;
        logic [2:0]        gain_range;
    } afe_prim_cfg_type;

    // auxiliary_converter_control layout
    typedef struct packed {
        logic             unipolar;
        afe_aux_chan_type chan;
    } afe_aux_cfg_type;

    // current_source_control layout
    typedef struct packed {
        logic burnout_current_enable;
        logic exc_comb_to_b;
        logic exc_combine;
        logic exc_b_en;
        logic exc_a_en;
    } afe_cur_cfg_type;

    // controls toward the analog pins (pins 1..4 in bits 0..3)
    typedef struct packed {
        logic [3:0]       prim_pos_sel;
        logic [3:0]       prim_neg_sel;
        logic [2:0]       gain_stage;
        afe_aux_chan_type aux_src;
        logic [3:0]       burn_src;
        logic [3:0]       burn_snk;
        logic [1:0]       exc_a_units;
        logic [1:0]       exc_b_units;
    } afe_front_type;

endpackage

// [rtl/afe_settle.sv]
// settling sequencer: lets results through after two filter outputs
`timescale 1ns/100ps
module afe_settle (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic restart,
    input  wire logic conv_done,
    output logic      settled,
    output logic      accept
);
    import afe_pkg::*;

    afe_settle_state_type state_q;

    // ****************************************************************
    // sequence
    // ****************************************************************
    // (R13) two outputs before valid
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            state_q <= SETTLE_WAIT0;
        end else if (conv_done) begin
            unique case (state_q)
                SETTLE_WAIT0: state_q <= SETTLE_WAIT1;
                SETTLE_WAIT1: state_q <= SETTLE_DONE;
                SETTLE_DONE:  state_q <= SETTLE_DONE;
                default:      state_q <= SETTLE_WAIT0;
            endcase
        end
    end

    // the second output after a restart already averages two chops
    assign settled = (state_q == SETTLE_DONE);
    assign accept  = conv_done && !restart && (state_q != SETTLE_WAIT0);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_restart;
        restart ##1 !restart;
    endsequence

    sequence s_first_out;
        conv_done && !restart;
    endsequence

    a_first_out_held: assert property ( // (R13)
        s_restart ##0 s_first_out |-> !accept)
        else $error("first filter output after restart was accepted");

    a_settle_cleared: assert property ( // (R3)
        restart |=> !settled ##0 !accept)
        else $error("settled or accepting right after restart");
endmodule

// [rtl/afe_ctrl.sv]
// analog front end control with an AXI4-Lite register slave
//
// What this block does
// (R1) primary selects three pairs or shorted pin two
// (R2) auxiliary selects pin three, four, five, temperature
// (R3) no valid result before settling after switch
// (R4) eight doubling primary gain ranges from smallest
// (R5) auxiliary has one fixed range, no gain
// (R6) per-converter unipolar bit changes only coding
// (R7) unipolar result is straight binary
// (R8) bipolar result is offset binary
// (R9) one bit switches both burnout sources
// (R10) burnout currents follow selected primary pair
// (R11) software reads full-scale open, zero shorted
// (R12) two excitation sources, separate or combined
// (R13) first result after two conversion periods
// (R14) setting change restarts settling, hides ready
`timescale 1ns/100ps
`include "afe_params.svh"
module afe_ctrl (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [23:0]          prim_sample,
    input  wire logic                 prim_sample_valid,
    input  wire logic [15:0]          aux_sample,
    input  wire logic                 aux_sample_valid,
    output afe_pkg::afe_front_type    front,
    output logic                      prim_result_ready,
    output logic                      aux_result_ready
);
    import afe_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    afe_prim_cfg_type prim_cfg_q;
    afe_aux_cfg_type  aux_cfg_q;
    afe_cur_cfg_type  cur_cfg_q;
    logic             aw_hold_q;
    logic             w_hold_q;
    logic [7:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic             wstrb0_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             rvalid_q;
    logic [1:0]       rresp_q;
    logic [31:0]      rdata_q;
    logic [23:0]      prim_result_q;
    logic [15:0]      aux_result_q;
    logic             prim_ready_q;
    logic             aux_ready_q;
    logic             do_wr;
    logic             do_rd;
    logic             wr_hit;
    logic             wr_prim;
    logic             wr_aux;
    logic             wr_cur;
    logic             prim_restart;
    logic             aux_restart;
    logic             prim_settled;
    logic             aux_settled;
    logic             prim_store;
    logic             aux_store;
    logic [23:0]      aux_coded;
    logic [7:0]       aux_pad;
    logic [3:0]       pos_sel;
    logic [3:0]       neg_sel;
    logic [1:0]       exc_sum;
    logic [31:0]      rd_mux;
    logic             rd_hit;

    // (R7) (R8) result coding from the filter's two's complement value
    function automatic logic [23:0] afe_code(input logic [23:0] v,
                                             input logic        uni);
        logic [23:0] r;
        r = {~v[23], v[22:0]};
        if (uni) begin
            if (v[23]) begin
                r = 24'h000000;
            end else if (v[22:0] == 23'h7fffff) begin
                r = 24'hffffff;
            end else begin
                r = {v[22:0], 1'b0};
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign do_wr  = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_hit = (awaddr_q == `AFE_OFF_PRIM_CFG) ||
                    (awaddr_q == `AFE_OFF_AUX_CFG)  ||
                    (awaddr_q == `AFE_OFF_CUR_CFG)  ||
                    (awaddr_q == `AFE_OFF_STATUS)   ||
                    (awaddr_q == `AFE_OFF_PRIM_RES) ||
                    (awaddr_q == `AFE_OFF_AUX_RES);
    // only byte lane 0 carries control fields
    assign wr_prim = do_wr && wstrb0_q && awaddr_q == `AFE_OFF_PRIM_CFG;
    assign wr_aux  = do_wr && wstrb0_q && awaddr_q == `AFE_OFF_AUX_CFG;
    assign wr_cur  = do_wr && wstrb0_q && awaddr_q == `AFE_OFF_CUR_CFG;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (do_wr) begin
            aw_hold_q <= 1'b0;
        end else if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wstrb0_q <= 1'b0;
        end else if (do_wr) begin
            w_hold_q <= 1'b0;
        end else if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `AFE_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `AFE_RESP_OKAY : `AFE_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // (R14) changed channel, range or coding restarts settling
    assign prim_restart = wr_prim &&
                          (wdata_q[5:0] != prim_cfg_q);
    assign aux_restart  = wr_aux && (wdata_q[2:0] != aux_cfg_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prim_cfg_q <= `AFE_PRIM_CFG_RST;
            aux_cfg_q  <= `AFE_AUX_CFG_RST;
            cur_cfg_q  <= `AFE_CUR_CFG_RST;
        end else begin
            if (wr_prim) begin
                prim_cfg_q <= wdata_q[5:0];
            end
            if (wr_aux) begin
                aux_cfg_q <= wdata_q[2:0];
            end
            if (wr_cur) begin
                cur_cfg_q <= wdata_q[4:0];
            end
        end
    end

    // ****************************************************************
    // settling and results
    // ****************************************************************
    // (R3) results gated until settled
    afe_settle u_prim_settle (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .restart   (prim_restart),
        .conv_done (prim_sample_valid),
        .settled   (prim_settled),
        .accept    (prim_store)
    );

    afe_settle u_aux_settle (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .restart   (aux_restart),
        .conv_done (aux_sample_valid),
        .settled   (aux_settled),
        .accept    (aux_store)
    );

    // (R6) unipolar bit only picks the coding
    // pad a full-scale word with ones so it still codes as all ones
    assign aux_pad   = (aux_sample == 16'h7fff) ? 8'hff : 8'h00;
    assign aux_coded = afe_code({aux_sample, aux_pad}, aux_cfg_q.unipolar);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prim_result_q <= 24'h000000;
            aux_result_q  <= 16'h0000;
        end else begin
            if (prim_store) begin
                prim_result_q <= afe_code(prim_sample, prim_cfg_q.unipolar);
            end
            if (aux_store) begin
                aux_result_q <= aux_coded[23:8];
            end
        end
    end

    // (R14) ready dropped on restart; a new result beats a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prim_ready_q <= 1'b0;
            aux_ready_q  <= 1'b0;
        end else begin
            if (prim_store) begin
                prim_ready_q <= 1'b1;
            end else if (prim_restart ||
                         (do_rd && s_axi_araddr[7:2] == 6'h04)) begin
                prim_ready_q <= 1'b0;
            end
            if (aux_store) begin
                aux_ready_q <= 1'b1;
            end else if (aux_restart ||
                         (do_rd && s_axi_araddr[7:2] == 6'h05)) begin
                aux_ready_q <= 1'b0;
            end
        end
    end

    assign prim_result_ready = prim_ready_q;
    assign aux_result_ready  = aux_ready_q;

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign do_rd = s_axi_arvalid && !rvalid_q;

    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[7:2], 2'b00})
            `AFE_OFF_PRIM_CFG: rd_mux[5:0]  = prim_cfg_q;
            `AFE_OFF_AUX_CFG:  rd_mux[2:0]  = aux_cfg_q;
            `AFE_OFF_CUR_CFG:  rd_mux[4:0]  = cur_cfg_q;
            `AFE_OFF_STATUS:   rd_mux[3:0]  = {aux_settled, prim_settled,
                                               aux_ready_q, prim_ready_q};
            `AFE_OFF_PRIM_RES: rd_mux[23:0] = prim_result_q;
            `AFE_OFF_AUX_RES:  rd_mux[15:0] = aux_result_q;
            default:           rd_hit       = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `AFE_RESP_OKAY;
        end else if (do_rd) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? `AFE_RESP_OKAY : `AFE_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // analog pin controls
    // ****************************************************************
    // (R1) primary pair routing, shorted input on pin two
    always_comb begin
        pos_sel = 4'h1;
        neg_sel = 4'h2;
        unique case (prim_cfg_q.chan)
            PRIM_CH_1_2: begin
                pos_sel = 4'h1;
                neg_sel = 4'h2;
            end
            PRIM_CH_3_4: begin
                pos_sel = 4'h4;
                neg_sel = 4'h8;
            end
            PRIM_CH_3_2: begin
                pos_sel = 4'h4;
                neg_sel = 4'h2;
            end
            PRIM_CH_2_2: begin
                pos_sel = 4'h2;
                neg_sel = 4'h2;
            end
        endcase
    end

    assign front.prim_pos_sel = pos_sel;
    assign front.prim_neg_sel = neg_sel;

    // (R4) gain range straight to the gain stage
    assign front.gain_stage = prim_cfg_q.gain_range;
    // (R2) auxiliary source; (R5) no gain path exists for it
    assign front.aux_src    = aux_cfg_q.chan;

    // (R9) (R10) burnout pair follows the selected pins
    for (genvar i = 0; i < 4; i++) begin : g_burn
        assign front.burn_src[i] = cur_cfg_q.burnout_current_enable &&
                                   pos_sel[i];
        assign front.burn_snk[i] = cur_cfg_q.burnout_current_enable &&
                                   neg_sel[i];
    end

    // (R12) separate sources, or both summed onto one pin
    assign exc_sum = {1'b0, cur_cfg_q.exc_a_en} +
                     {1'b0, cur_cfg_q.exc_b_en};
    assign front.exc_a_units = !cur_cfg_q.exc_combine ?
                               {1'b0, cur_cfg_q.exc_a_en} :
                               (cur_cfg_q.exc_comb_to_b ? 2'h0 : exc_sum);
    assign front.exc_b_units = !cur_cfg_q.exc_combine ?
                               {1'b0, cur_cfg_q.exc_b_en} :
                               (cur_cfg_q.exc_comb_to_b ? exc_sum : 2'h0);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_short_input: assert property ( // (R1)
        prim_cfg_q.chan == PRIM_CH_2_2 |->
        front.prim_pos_sel == 4'h2 && front.prim_neg_sel == 4'h2)
        else $error("shorted input not on pin two");

    a_restart_hides: assert property ( // (R14)
        prim_restart |=> !prim_result_ready ##0 !prim_settled)
        else $error("ready shown right after a setting change");

    a_bipolar_code: assert property ( // (R8)
        prim_store && !prim_cfg_q.unipolar |=>
        prim_result_q == {~$past(prim_sample[23]), $past(prim_sample[22:0])})
        else $error("bipolar coding wrong");

    a_unipolar_zero: assert property ( // (R7)
        prim_store && prim_cfg_q.unipolar && prim_sample[23] |=>
        prim_result_q == 24'h000000 ##0 prim_result_ready)
        else $error("unipolar negative input not coded as zero");

    a_burnout_off: assert property ( // (R9)
        !cur_cfg_q.burnout_current_enable |->
        front.burn_src == 4'h0 && front.burn_snk == 4'h0)
        else $error("burnout current on while disabled");

    a_burnout_route: assert property ( // (R10)
        cur_cfg_q.burnout_current_enable |->
        front.burn_src == front.prim_pos_sel &&
        front.burn_snk == front.prim_neg_sel)
        else $error("burnout current not on selected pair");

    a_excite_total: assert property ( // (R12)
        front.exc_a_units + front.exc_b_units == exc_sum)
        else $error("excitation current lost or added");

    a_write_reply: assert property ( // write response on the bus
        do_wr |=> s_axi_bvalid ##0 !aw_hold_q)
        else $error("write not answered in one cycle");
endmodule

// [dv/afe_sensor_model.sv]
// sensor-side model: filter output pulses toward the control block
`timescale 1ns/100ps
module afe_sensor_model (
    input  wire logic   aclk,
    output logic [23:0] prim_sample,
    output logic        prim_sample_valid,
    output logic [15:0] aux_sample,
    output logic        aux_sample_valid
);
    initial begin
        prim_sample = 24'h000000;
        prim_sample_valid = 1'b0;
        aux_sample = 16'h0000;
        aux_sample_valid = 1'b0;
    end
    // one-cycle pulse; data shows its inverse after, never a stale copy
    task automatic pulse(input logic [23:0] p, input logic [15:0] a);
        @(posedge aclk);
        prim_sample <= p;
        aux_sample <= a;
        prim_sample_valid <= 1'b1;
        aux_sample_valid <= 1'b1;
        @(posedge aclk);
        prim_sample <= ~p;
        aux_sample <= ~a;
        prim_sample_valid <= 1'b0;
        aux_sample_valid <= 1'b0;
    endtask
endmodule

// [dv/afe_ctrl_bench.sv]
// self-checking bench of the analog front end control block
`timescale 1ns/100ps
`include "afe_params.svh"
module afe_ctrl_bench;
    import afe_pkg::*;
    // ********
    // signals
    // ********
    logic          aclk = 1'b0, aresetn = 1'b0;
    logic          awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic          awr, wrd, bv, arr, rv, prr, axr, ppv, apv;
    logic [7:0]    awa = 8'h00, ara = 8'h00;
    logic [31:0]   wd = 32'h0, rdat;
    logic [1:0]    br, rr;
    logic [23:0]   ps;
    logic [15:0]   axs;
    afe_front_type front;
    int            n_mismatch = 0, num_checks = 0;
    logic [7:0]    chan_tab [4] = '{8'h12, 8'h48, 8'h42, 8'h22};
    logic [7:0]    exc_tab [6] = '{8'h00, 8'h14, 8'h21, 8'h35, 8'h78, 8'hf2};

    always #4 aclk = ~aclk;

    afe_ctrl afe_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .prim_sample(ps),
        .prim_sample_valid(ppv), .aux_sample(axs),
        .aux_sample_valid(apv), .front(front),
        .prim_result_ready(prr), .aux_result_ready(axr));

    afe_sensor_model afe_sensor_model_inst (.aclk(aclk),
        .prim_sample(ps), .prim_sample_valid(ppv),
        .aux_sample(axs), .aux_sample_valid(apv));

    // ********
    // tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bready and rready stay high, so the answer is taken when seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ah;
        logic wh;
        ah = 1'b1;
        wh = 1'b1;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge aclk);
            if (ah && awr) begin
                ah = 1'b0;
                awv <= 1'b0;
            end
            if (wh && wrd) begin
                wh = 1'b0;
                wv <= 1'b0;
            end
        end while (bv !== 1'b1);
        r = br;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ah;
        ah = 1'b1;
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge aclk);
            if (ah && arr) begin
                ah = 1'b0;
                arv <= 1'b0;
            end
        end while (rv !== 1'b1);
        d = rdat;
        r = rr;
    endtask

    // restart by a config change, then two filter outputs, then read
    task automatic meas(input bit aux, input logic [5:0] cfg,
                        input logic [23:0] s, input logic [23:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        wr(aux ? `AFE_OFF_AUX_CFG : `AFE_OFF_PRIM_CFG, {26'h0, cfg}, r);
        afe_sensor_model_inst.pulse(aux ? 24'h0 : s, aux ? s[15:0] : 16'h0);
        @(posedge aclk);
        chk("ready one output", 0, aux ? axr : prr);
        afe_sensor_model_inst.pulse(aux ? 24'h0 : s, aux ? s[15:0] : 16'h0);
        @(posedge aclk);
        chk("ready two outputs", 1, aux ? axr : prr);
        rd(aux ? `AFE_OFF_AUX_RES : `AFE_OFF_PRIM_RES, d, r);
        chk("result code", e, d);
        chk("ready cleared", 0, aux ? axr : prr);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ********
    // tests
    // ********
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 3; i++) begin
            rd({i[5:0], 2'b00}, d, r);
            chk("config reset", 0, d);
        end
        chk("pins reset", 8'h12,
            {front.prim_pos_sel, front.prim_neg_sel});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`AFE_OFF_PRIM_CFG, i << 4, r);
            chk("prim pins", chan_tab[i],
                {front.prim_pos_sel, front.prim_neg_sel});
            wr(`AFE_OFF_AUX_CFG, i, r);
            chk("aux source", i, front.aux_src);
        end
        $display("test channels done");
        for (int i = 0; i < 8; i++) begin
            wr(`AFE_OFF_PRIM_CFG, i | 8, r);
            chk("gain", i, front.gain_stage);
            chk("pins unipolar", 8'h12,
                {front.prim_pos_sel, front.prim_neg_sel});
        end
        wr(`AFE_OFF_AUX_CFG, 32'h4, r);
        chk("gain after aux", 7, front.gain_stage);
        $display("test gain done");
        wr(`AFE_OFF_PRIM_CFG, 32'h10, r);
        wr(`AFE_OFF_CUR_CFG, 32'h10, r);
        chk("burnout on", 8'h48, {front.burn_src, front.burn_snk});
        wr(`AFE_OFF_PRIM_CFG, 32'h20, r);
        chk("burnout follows", 8'h42, {front.burn_src, front.burn_snk});
        wr(`AFE_OFF_CUR_CFG, 32'h0, r);
        chk("burnout off", 0, {front.burn_src, front.burn_snk});
        for (int i = 0; i < 6; i++) begin
            wr(`AFE_OFF_CUR_CFG, exc_tab[i][7:4], r);
            chk("excitation", exc_tab[i][3:0],
                {front.exc_a_units, front.exc_b_units});
        end
        $display("test currents done");
        meas(0, 6'h00, 24'h000000, 24'h800000);
        meas(0, 6'h11, 24'h800000, 24'h000000);
        meas(0, 6'h22, 24'h7fffff, 24'hffffff);
        meas(0, 6'h08, 24'h000000, 24'h000000);
        meas(0, 6'h09, 24'h400000, 24'h800000);
        meas(0, 6'h0a, 24'h7fffff, 24'hffffff);
        meas(0, 6'h0b, 24'hffffff, 24'h000000);
        meas(1, 6'h01, 24'h000000, 24'h008000);
        meas(1, 6'h02, 24'h008000, 24'h000000);
        meas(1, 6'h05, 24'h004000, 24'h008000);
        meas(1, 6'h06, 24'h00ffff, 24'h000000);
        meas(1, 6'h05, 24'h007fff, 24'h00ffff);
        $display("test coding done");
        wr(`AFE_OFF_PRIM_CFG, 32'h0b, r);
        wr(`AFE_OFF_CUR_CFG, 32'h01, r);
        afe_sensor_model_inst.pulse(24'h000100, 16'h0100);
        @(posedge aclk);
        chk("ready no restart", 1, prr);
        rd(`AFE_OFF_STATUS, d, r);
        chk("status", 4'hf, d[3:0]);
        $display("test no restart done");
        wr(8'h20, 32'h1, r);
        chk("bresp unmapped", `AFE_RESP_SLVERR, r);
        rd(8'h20, d, r);
        chk("rresp unmapped", `AFE_RESP_SLVERR, r);
        chk("rdata unmapped", 0, d);
        wr(`AFE_OFF_PRIM_RES, 32'hffffffff, r);
        chk("bresp read-only", `AFE_RESP_OKAY, r);
        $display("test bus errors done");
        tally_and_finish;
    end
endmodule
